// ---- src/lsr_top.v ----
`timescale 1ns/10ps
`include "lsr_consts.vh"
module lsr_top
(
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        clk_en,
   input  wire        scl_in,
   input  wire        sda_in,
   output wire        sda_out,
   output wire        sda_oe,
   output reg         irq_n_ff,
   input  wire [15:0] chan0_result,
   input  wire [15:0] chan1_result,
   output reg         high_gain_ff,
   output reg         powered_ff
);
   reg  [7:0]  cmd_ff;
   reg  [7:0]  control_ff;
   reg  [7:0]  timing_ff;
   reg  [7:0]  irq_style_select_ff;
   reg  [7:0]  thr_ff [0:3];
   reg  [7:0]  res_ff [0:3];
   reg  [7:0]  shadow_ff [0:1];
   reg  [3:0]  persist_cnt_ff;
   reg         irq_ff;
   reg         byte_idx_ff;
   reg         test_pend_ff;
   reg  [7:0]  nxt_rd;
   wire        wr_stb;
   wire        rd_stb;
   wire        start_stb;
   wire        ara_done;
   wire [7:0]  wr_byte;
   wire        sda_oe_w;
   wire        conv_done;
   wire [3:0]  reg_idx = cmd_ff[3:0] + {3'h0, byte_idx_ff};
   wire [15:0] thr_lo = {thr_ff[1], thr_ff[0]};
   wire [15:0] thr_hi = {thr_ff[3], thr_ff[2]};
   wire [15:0] ch0_new = chan0_result;
   wire        outside = (ch0_new < thr_lo) || (ch0_new > thr_hi);
   wire [1:0]  style = irq_style_select_ff[5:4];
   wire [3:0]  persist = irq_style_select_ff[3:0];
   wire        fire;
   integer     i;

   assign sda_out = 1'b0;
   assign sda_oe  = sda_oe_w;

   lsr_i2c_slave u_slave
   (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .clk_en       (clk_en),
      .scl_in       (scl_in),
      .sda_in       (sda_in),
      .sda_oe_ff    (sda_oe_w),
      .rd_data      (nxt_rd),
      .ara_ok       (irq_ff && style[1]),
      .wr_strobe_ff (wr_stb),
      .rd_strobe_ff (rd_stb),
      .start_ff     (start_stb),
      .ara_done_ff  (ara_done),
      .wr_byte_ff   (wr_byte)
   );

   lsr_integrator u_integ
   (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .clk_en     (clk_en),
      .powered    (control_ff[1:0] == `LSR_POWER_UP),
      .integ_sel  (timing_ff[1:0]),
      .manual_run (timing_ff[`LSR_TIM_MANUAL_BIT]),
      .done_ff    (conv_done)
   );

   // Read mux; high bytes come from the shadow, not the live result
   always @*
   begin
      case (reg_idx)
         `LSR_REG_CONTROL:   nxt_rd = control_ff;
         `LSR_REG_TIMING:    nxt_rd = timing_ff;
         `LSR_REG_THR_LO_L:  nxt_rd = thr_ff[0];
         `LSR_REG_THR_LO_H:  nxt_rd = thr_ff[1];
         `LSR_REG_THR_HI_L:  nxt_rd = thr_ff[2];
         `LSR_REG_THR_HI_H:  nxt_rd = thr_ff[3];
         `LSR_REG_INTERRUPT: nxt_rd = irq_style_select_ff;
         `LSR_REG_CH0_LOW:   nxt_rd = res_ff[0];
         `LSR_REG_CH0_HIGH:  nxt_rd = shadow_ff[0];
         `LSR_REG_CH1_LOW:   nxt_rd = res_ff[2];
         `LSR_REG_CH1_HIGH:  nxt_rd = shadow_ff[1];
         default:            nxt_rd = 8'h00;
      endcase
   end

   // Persistence decision: 0 every conversion, 1 any outlier, N consecutive
   // Sum kept at five bits so a saturated count of 15 cannot wrap to zero
   assign fire = conv_done && ((persist == 4'h0) ||
                 (outside && ({1'b0, persist_cnt_ff} + 5'h01 >= {1'b0, persist})));

   // Command pointer, settings and result capture
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cmd_ff       <= 8'h00;
         control_ff   <= `LSR_CONTROL_RST;
         timing_ff    <= `LSR_TIMING_RST;
         irq_style_select_ff      <= `LSR_INTERRUPT_RST;
         byte_idx_ff  <= 1'b0;
         high_gain_ff <= 1'b0;
         powered_ff   <= 1'b0;
         for (i = 0; i < 4; i = i + 1)
         begin
            thr_ff[i] <= 8'h00;
            res_ff[i] <= `LSR_RESULT_RST;
         end
         shadow_ff[0] <= `LSR_RESULT_RST;
         shadow_ff[1] <= `LSR_RESULT_RST;
      end
      else if (clk_en)
      begin
         high_gain_ff <= timing_ff[`LSR_TIM_GAIN_BIT];
         powered_ff   <= (control_ff[1:0] == `LSR_POWER_UP);
         if (start_stb)
            byte_idx_ff <= 1'b0;
         // Both channels captured in one cycle, never split
         if (conv_done)
         begin
            res_ff[0] <= chan0_result[7:0];
            res_ff[1] <= chan0_result[15:8];
            res_ff[2] <= chan1_result[7:0];
            res_ff[3] <= chan1_result[15:8];
         end
         // Low byte read latches the high byte; later conversions cannot touch it
         if (rd_stb)
         begin
            if (reg_idx == `LSR_REG_CH0_LOW)
               shadow_ff[0] <= res_ff[1];
            if (reg_idx == `LSR_REG_CH1_LOW)
               shadow_ff[1] <= res_ff[3];
            if (cmd_ff[`LSR_CMD_WORD_BIT])
               byte_idx_ff <= ~byte_idx_ff;
         end
         if (wr_stb)
         begin
            if (wr_byte[`LSR_CMD_SEL_BIT])
            begin
               cmd_ff      <= wr_byte;
               byte_idx_ff <= 1'b0;
            end
            else
            begin
               // Result registers have no write path
               case (reg_idx)
                  `LSR_REG_CONTROL:   control_ff <= wr_byte;
                  `LSR_REG_TIMING:    timing_ff  <= wr_byte;
                  `LSR_REG_THR_LO_L:  thr_ff[0]  <= wr_byte;
                  `LSR_REG_THR_LO_H:  thr_ff[1]  <= wr_byte;
                  `LSR_REG_THR_HI_L:  thr_ff[2]  <= wr_byte;
                  `LSR_REG_THR_HI_H:  thr_ff[3]  <= wr_byte;
                  `LSR_REG_INTERRUPT: irq_style_select_ff    <= {2'h0, wr_byte[5:0]};
                  default:            ;
               endcase
               if (cmd_ff[`LSR_CMD_WORD_BIT])
                  byte_idx_ff <= ~byte_idx_ff;
            end
         end
      end
   end

   // Interrupt state: set wins over any clear in the same cycle
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         persist_cnt_ff <= 4'h0;
         irq_ff         <= 1'b0;
         test_pend_ff   <= 1'b0;
         irq_n_ff       <= 1'b1;
      end
      else if (clk_en)
      begin
         test_pend_ff <= wr_stb && !wr_byte[`LSR_CMD_SEL_BIT] &&
                         reg_idx == `LSR_REG_INTERRUPT && wr_byte[5:4] == `LSR_STYLE_TEST;
         if (wr_stb && !wr_byte[`LSR_CMD_SEL_BIT] && reg_idx == `LSR_REG_INTERRUPT)
            persist_cnt_ff <= 4'h0;
         else if (conv_done)
         begin
            if (!outside)
               persist_cnt_ff <= 4'h0;
            else if (persist_cnt_ff != 4'hf)
               persist_cnt_ff <= persist_cnt_ff + 4'h1;
         end
         if ((fire && style != `LSR_STYLE_OFF) || test_pend_ff)
            irq_ff <= 1'b1;
         else if (style == `LSR_STYLE_OFF)
            irq_ff <= 1'b0;
         else if (style == `LSR_STYLE_LEVEL && wr_stb &&
                  wr_byte[`LSR_CMD_SEL_BIT] && wr_byte[`LSR_CMD_CLEAR_BIT])
            irq_ff <= 1'b0;
         else if (style[1] && ara_done)
            irq_ff <= 1'b0;
         irq_n_ff <= ~(irq_ff && style != `LSR_STYLE_OFF);
      end
   end
endmodule

// ---- src/lsr_consts.vh ----
`ifndef LSR_CONSTS_VH
`define LSR_CONSTS_VH
// Register indices (command byte bits 3:0)
`define LSR_REG_CONTROL    4'h0
`define LSR_REG_TIMING     4'h1
`define LSR_REG_THR_LO_L   4'h2
`define LSR_REG_THR_LO_H   4'h3
`define LSR_REG_THR_HI_L   4'h4
`define LSR_REG_THR_HI_H   4'h5
`define LSR_REG_INTERRUPT  4'h6
`define LSR_REG_CH0_LOW    4'h0c
`define LSR_REG_CH0_HIGH   4'h0d
`define LSR_REG_CH1_LOW    4'h0e
`define LSR_REG_CH1_HIGH   4'h0f
// Command byte fields
`define LSR_CMD_SEL_BIT    7
`define LSR_CMD_CLEAR_BIT  6
`define LSR_CMD_WORD_BIT   5
// Reset values and the power-up control code
`define LSR_CONTROL_RST    8'h00
`define LSR_TIMING_RST     8'h02
`define LSR_INTERRUPT_RST  8'h00
`define LSR_RESULT_RST     8'h00
`define LSR_POWER_UP       2'h3
// Timing and interrupt fields
`define LSR_TIM_GAIN_BIT   4
`define LSR_TIM_MANUAL_BIT 3
`define LSR_INTEG_13MS7    2'h0
`define LSR_INTEG_101MS    2'h1
`define LSR_INTEG_402MS    2'h2
`define LSR_INTEG_MANUAL   2'h3
`define LSR_STYLE_OFF      2'h0
`define LSR_STYLE_LEVEL    2'h1
`define LSR_STYLE_ALERT    2'h2
`define LSR_STYLE_TEST     2'h3
// Bus addresses
`define LSR_ALERT_ADDR     7'h0c
`define LSR_DEV_ADDR       7'h39
// Integration times in microseconds, clock in MHz
`define LSR_CLK_MHZ        100
`define LSR_T0_US          13700
`define LSR_T1_US          101000
`define LSR_T2_US          402000
`define LSR_CYC(us)        ((us) * `LSR_CLK_MHZ)
`endif

// ---- src/lsr_i2c_slave.v ----
`timescale 1ns/10ps
`include "lsr_consts.vh"
// Byte level I2C/SMBus slave; SCL and SDA are oversampled by ref_clk
module lsr_i2c_slave
(
   input  wire       ref_clk,
   input  wire       rst_n,
   input  wire       clk_en,
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        sda_oe_ff,
   input  wire [7:0] rd_data,
   input  wire       ara_ok,
   output reg        wr_strobe_ff,
   output reg        rd_strobe_ff,
   output reg        start_ff,
   output reg        ara_done_ff,
   output reg  [7:0] wr_byte_ff
);
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_ADDR = 6'h02;
   localparam [5:0] S_WACK = 6'h04;
   localparam [5:0] S_WRX  = 6'h08;
   localparam [5:0] S_RTX  = 6'h10;
   localparam [5:0] S_RACK = 6'h20;

   reg [1:0] scl_sync_ff;
   reg [1:0] sda_sync_ff;
   reg       scl_d_ff;
   reg       sda_d_ff;
   reg [5:0] state_ff;
   reg [3:0] bit_cnt_ff;
   reg [7:0] shift_ff;
   reg       rd_mode_ff;
   reg       is_ara_ff;
   reg       ack_due_ff;
   wire      scl_rise = scl_sync_ff[1] & ~scl_d_ff;
   wire      scl_fall = ~scl_sync_ff[1] & scl_d_ff;
   wire      start_c = scl_sync_ff[1] & scl_d_ff & sda_d_ff & ~sda_sync_ff[1];
   wire      stop_c = scl_sync_ff[1] & scl_d_ff & ~sda_d_ff & sda_sync_ff[1];
   wire [7:0] ara_byte = {`LSR_DEV_ADDR, 1'b1};

   // Two-flop synchronisers; edges are found on the second stage only
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         scl_d_ff    <= 1'b1;
         sda_d_ff    <= 1'b1;
      end
      else if (clk_en)
      begin
         scl_sync_ff <= {scl_sync_ff[0], scl_in};
         sda_sync_ff <= {sda_sync_ff[0], sda_in};
         scl_d_ff    <= scl_sync_ff[1];
         sda_d_ff    <= sda_sync_ff[1];
      end
   end

   // Protocol engine: data sampled on SCL rise, driven on SCL fall
   always @(posedge ref_clk)
   begin
      wr_strobe_ff <= 1'b0;
      rd_strobe_ff <= 1'b0;
      start_ff     <= 1'b0;
      ara_done_ff  <= 1'b0;
      if (!rst_n)
      begin
         state_ff     <= S_IDLE;
         bit_cnt_ff   <= 4'h0;
         shift_ff     <= 8'h00;
         rd_mode_ff   <= 1'b0;
         is_ara_ff    <= 1'b0;
         ack_due_ff   <= 1'b0;
         sda_oe_ff    <= 1'b0;
         wr_byte_ff   <= 8'h00;
         wr_strobe_ff <= 1'b0;
         rd_strobe_ff <= 1'b0;
         start_ff     <= 1'b0;
         ara_done_ff  <= 1'b0;
      end
      else if (clk_en)
      begin
         if (stop_c)
         begin
            state_ff  <= S_IDLE;
            sda_oe_ff <= 1'b0;
         end
         else if (start_c)
         begin
            state_ff   <= S_ADDR;
            bit_cnt_ff <= 4'h0;
            sda_oe_ff  <= 1'b0;
            start_ff   <= 1'b1;
         end
         else
         begin
            case (state_ff)
               S_ADDR, S_WRX:
               begin
                  if (scl_rise)
                  begin
                     shift_ff   <= {shift_ff[6:0], sda_sync_ff[1]};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
                  else if (scl_fall && bit_cnt_ff == 4'h8)
                  begin
                     bit_cnt_ff <= 4'h0;
                     if (state_ff == S_WRX)
                     begin
                        wr_byte_ff   <= shift_ff;
                        wr_strobe_ff <= 1'b1;
                        sda_oe_ff    <= 1'b1;
                        ack_due_ff   <= 1'b0;
                        state_ff     <= S_WACK;
                     end
                     else if (shift_ff[7:1] == `LSR_DEV_ADDR ||
                              (shift_ff[7:1] == `LSR_ALERT_ADDR && shift_ff[0] && ara_ok))
                     begin
                        // Alert answer: own address in the upper seven bits
                        is_ara_ff  <= (shift_ff[7:1] == `LSR_ALERT_ADDR);
                        rd_mode_ff <= shift_ff[0];
                        sda_oe_ff  <= 1'b1;
                        ack_due_ff <= shift_ff[0];
                        state_ff   <= S_WACK;
                     end
                     else
                        state_ff <= S_IDLE;
                  end
               end
               S_WACK:
               begin
                  if (scl_fall)
                  begin
                     if (ack_due_ff)
                     begin
                        shift_ff     <= is_ara_ff ? ara_byte : rd_data;
                        sda_oe_ff    <= is_ara_ff ? ~ara_byte[7] : ~rd_data[7];
                        rd_strobe_ff <= ~is_ara_ff;
                        bit_cnt_ff   <= 4'h1;
                        state_ff     <= S_RTX;
                     end
                     else
                     begin
                        sda_oe_ff <= 1'b0;
                        state_ff  <= S_WRX;
                     end
                  end
               end
               S_RTX:
               begin
                  // Lost arbitration: a low line while we release it
                  if (scl_rise && !sda_oe_ff && !sda_sync_ff[1])
                     state_ff <= S_IDLE;
                  else if (scl_fall)
                  begin
                     if (bit_cnt_ff == 4'h8)
                     begin
                        sda_oe_ff <= 1'b0;
                        state_ff  <= S_RACK;
                        if (is_ara_ff)
                           ara_done_ff <= 1'b1;
                     end
                     else
                     begin
                        sda_oe_ff  <= ~shift_ff[7 - bit_cnt_ff[2:0]];
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     end
                  end
               end
               S_RACK:
               begin
                  if (scl_rise)
                     state_ff <= sda_sync_ff[1] ? S_IDLE : S_WACK;
                  if (scl_rise)
                     ack_due_ff <= 1'b1;
                  if (scl_rise)
                     is_ara_ff <= 1'b0;
               end
               default:
                  state_ff <= S_IDLE;
            endcase
         end
      end
   end
endmodule

// ---- src/lsr_integrator.v ----
`timescale 1ns/10ps
`include "lsr_consts.vh"
// Integration period timer; pulses once per completed conversion
module lsr_integrator
(
   input  wire       ref_clk,
   input  wire       rst_n,
   input  wire       clk_en,
   input  wire       powered,
   input  wire [1:0] integ_sel,
   input  wire       manual_run,
   output reg        done_ff
);
   parameter [31:0] CYC0 = `LSR_CYC(`LSR_T0_US);
   parameter [31:0] CYC1 = `LSR_CYC(`LSR_T1_US);
   parameter [31:0] CYC2 = `LSR_CYC(`LSR_T2_US);

   reg [31:0] cnt_ff;
   reg        man_d_ff;
   reg [31:0] limit;

   // Period limit follows the timing register at once
   always @*
   begin
      case (integ_sel)
         `LSR_INTEG_13MS7: limit = CYC0;
         `LSR_INTEG_101MS: limit = CYC1;
         default:          limit = CYC2;
      endcase
   end

   // Free-running periods, or one period bounded by manual start and stop
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cnt_ff   <= 32'h0;
         man_d_ff <= 1'b0;
         done_ff  <= 1'b0;
      end
      else if (clk_en)
      begin
         done_ff  <= 1'b0;
         man_d_ff <= manual_run;
         if (!powered)
            cnt_ff <= 32'h0;
         else if (integ_sel == `LSR_INTEG_MANUAL)
         begin
            cnt_ff <= 32'h0;
            if (man_d_ff && !manual_run)
               done_ff <= 1'b1;
         end
         else if (cnt_ff + 32'h1 >= limit)
         begin
            cnt_ff  <= 32'h0;
            done_ff <= 1'b1;
         end
         else
            cnt_ff <= cnt_ff + 32'h1;
      end
   end
endmodule

// ---- tb/lsr_host.sv ----
`timescale 1ns/10ps
`include "lsr_consts.vh"
// Bus master model; SDA has a pull-up, so a released line reads high
module lsr_host
(
   input  wire sda_line,
   output reg  scl_ff,
   output reg  sda_ff
);
   // Clock stands still high between frames
   initial
   begin
      scl_ff = 1'b1;
      sda_ff = 1'b1;
   end
   // One 125 ns bit cell; SDA moves only while SCL is low
   task bit_io(input reg b, output reg r);
   begin
      #31 sda_ff = b;
      #31 scl_ff = 1'b1;
      #31 r = sda_line;
      #32 scl_ff = 1'b0;
   end
   endtask
   // Also serves as repeated start: SDA is raised while SCL is low
   task start;
   begin
      sda_ff = 1'b1;
      #31 scl_ff = 1'b1;
      #31 sda_ff = 1'b0;
      #31 scl_ff = 1'b0;
   end
   endtask
   task stop;
   begin
      #31 sda_ff = 1'b0;
      #31 scl_ff = 1'b1;
      #31 sda_ff = 1'b1;
      #31;
   end
   endtask
   // Eight bits MSB first, then the acknowledge cell
   task byte_io(input [7:0] tx, input reg nak, output reg [7:0] rx, output reg ack);
      integer i;
      reg     r;
   begin
      for (i = 7; i >= 0; i = i - 1)
      begin
         bit_io(tx[i], r);
         rx = {rx[6:0], r};
      end
      bit_io(nak, ack);
   end
   endtask
   // Receive byte from the shared alert address, closed by a NACK
   task alert_rd(output reg [7:0] rx, output reg ack);
      reg [7:0] dmy;
      reg       na;
   begin
      start;
      byte_io({`LSR_ALERT_ADDR, 1'b1}, 1'b1, dmy, ack);
      byte_io(8'hff, 1'b1, rx, na);
      stop;
   end
   endtask
endmodule

// ---- tb/lsr_chk.sv ----
`timescale 1ns/10ps
// Port level watcher; the pins are raw, so windows allow for sync lag
module lsr_chk
(
   input wire        ref_clk,
   input wire        rst_n,
   input wire        clk_en,
   input wire        scl_in,
   input wire        sda_in,
   input wire        sda_out,
   input wire        sda_oe,
   input wire        irq_n_ff,
   input wire [15:0] chan0_result,
   input wire [15:0] chan1_result,
   input wire        high_gain_ff,
   input wire        powered_ff
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Start on the pins: SDA falls while SCL is high
   sequence seq_start;
      $fell(sda_in) && scl_in && $past(scl_in);
   endsequence
   a_sda_value_low: assert property (sda_out == 1'b0)
      else $error("open drain data value not low");
   a_reset_irq_off: assert property (disable iff (1'b0) !rst_n && clk_en |=> irq_n_ff)
      else $error("interrupt active after reset");
   a_reset_power_off: assert property (disable iff (1'b0)
      !rst_n && clk_en |=> !powered_ff && !high_gain_ff)
      else $error("powered or high gain after reset");
   a_reset_bus_free: assert property (disable iff (1'b0) !rst_n && clk_en |=> !sda_oe)
      else $error("data line driven after reset");
   a_oe_stable_high: assert property (scl_in && $past(scl_in) && $past(scl_in, 2)
      && $past(scl_in, 3) |-> $stable(sda_oe))
      else $error("data drive changed while clock high");
   a_oe_start_quiet: assert property (seq_start |-> !sda_oe [*8])
      else $error("data line driven right after start");
   a_irq_hold_idle: assert property ((scl_in && sda_in) [*8] ##0 !irq_n_ff |=> !irq_n_ff)
      else $error("interrupt released with no bus action");
   a_cfg_hold_idle: assert property ((scl_in && sda_in) [*8]
      |=> $stable(powered_ff) && $stable(high_gain_ff))
      else $error("settings changed with no bus action");
endmodule
bind lsr_top lsr_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .irq_n_ff(irq_n_ff), .chan0_result(chan0_result), .chan1_result(chan1_result),
   .high_gain_ff(high_gain_ff), .powered_ff(powered_ff));

// ---- tb/lsr_top_tb.sv ----
`timescale 1ns/10ps
`include "lsr_consts.vh"
module lsr_top_tb;
   reg         ref_clk;
   reg         rst_n;
   reg  [15:0] ch0;
   reg  [15:0] ch1;
   wire        scl;
   wire        sda_h;
   wire        sda_oe;
   wire        irq_n;
   wire        gain;
   wire        pwr;
   wire        sda_line;
   integer     n_errors;
   integer     checks;
   integer     cyc;
   reg  [15:0] rd;
   reg  [7:0]  b;
   reg         a;
   // Pull-up wire: low when either party pulls it
   assign sda_line = sda_h & ~sda_oe;
   lsr_host host_u (.sda_line(sda_line), .scl_ff(scl), .sda_ff(sda_h));
   lsr_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .scl_in(scl),
      .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .irq_n_ff(irq_n),
      .chan0_result(ch0), .chan1_result(ch1), .high_gain_ff(gain), .powered_ff(pwr));
   always #5 ref_clk = ~ref_clk;
   task final_report;
   begin
      if (n_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   // Cuts a hang short well past the expected run length
   always @(posedge ref_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 80000)
      begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED at %0t: timeout", $time);
         final_report;
      end
   end
   task check(input [15:0] got, input [15:0] exp);
   begin
      checks = checks + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // Byte that the device must acknowledge
   task put(input [7:0] v);
   begin
      host_u.byte_io(v, 1'b1, b, a);
      check({15'h0, a}, 16'h0);
   end
   endtask
   // n data bytes, low byte first; settle lets the synchronisers catch up
   task wr(input [7:0] cmd, input [15:0] d, input integer n);
   begin
      host_u.start;
      put({`LSR_DEV_ADDR, 1'b0});
      put(cmd);
      if (n > 0)
         put(d[7:0]);
      if (n > 1)
         put(d[15:8]);
      host_u.stop;
      repeat (4) @(posedge ref_clk);
   end
   endtask
   // Repeated start read; the last byte is not acknowledged
   task rdn(input [7:0] cmd, input integer n, input [15:0] exp);
   begin
      host_u.start;
      put({`LSR_DEV_ADDR, 1'b0});
      put(cmd);
      host_u.start;
      put({`LSR_DEV_ADDR, 1'b1});
      host_u.byte_io(8'hff, n == 1, rd[7:0], a);
      if (n > 1)
         host_u.byte_io(8'hff, 1'b1, rd[15:8], a);
      else
         rd[15:8] = 8'h00;
      host_u.stop;
      check(rd, exp);
   end
   endtask
   // Manual window; the live values are taken when it closes
   task conv(input [15:0] c0, input [15:0] c1, input reg e);
   begin
      @(posedge ref_clk);
      ch0 <= c0;
      ch1 <= c1;
      wr(8'h81, 16'h000b, 1);
      wr(8'h81, 16'h0003, 1);
      repeat (8) @(posedge ref_clk);
      check({15'h0, irq_n}, {15'h0, e});
   end
   endtask
   initial
   begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      ch0 = 16'h0000;
      ch1 = 16'h0000;
      n_errors = 0;
      checks = 0;
      cyc = 0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check({14'h0, pwr, gain}, 16'h0000);
      check({15'h0, irq_n}, 16'h0001);
      rdn(8'hac, 2, 16'h0000);
      rdn(8'hae, 2, 16'h0000);
      wr(8'h80, 16'h0003, 1);
      wr(8'h81, 16'h0011, 1);
      check({14'h0, pwr, gain}, 16'h0003);
      wr(8'h81, 16'h0001, 1);
      check({15'h0, gain}, 16'h0000);
      wr(8'h81, 16'h0003, 1);
      // Results, pairing and the high byte shadow
      conv(16'h1234, 16'h5678, 1'b1);
      rdn(8'hac, 2, 16'h1234);
      rdn(8'hae, 2, 16'h5678);
      rdn(8'h8c, 1, 16'h0034);
      conv(16'h9abc, 16'h0def, 1'b1);
      rdn(8'h8d, 1, 16'h0012);
      wr(8'hac, 16'hffff, 2);
      rdn(8'hac, 2, 16'h9abc);
      rdn(8'h8e, 1, 16'h00ef);
      rdn(8'h8f, 1, 16'h000d);
      // Level style, every conversion, thresholds ignored
      wr(8'h86, 16'h0010, 1);
      conv(16'h0000, 16'h0000, 1'b0);
      rdn(8'h8c, 1, 16'h0000);
      check({15'h0, irq_n}, 16'h0000);
      wr(8'hc0, 16'h0000, 0);
      check({15'h0, irq_n}, 16'h0001);
      // Window 1000..2000 with persistence 3, run broken by an inside value
      wr(8'ha2, 16'h1000, 2);
      wr(8'ha4, 16'h2000, 2);
      wr(8'h86, 16'h0013, 1);
      conv(16'h3000, 16'h0000, 1'b1);
      conv(16'h3000, 16'h0000, 1'b1);
      conv(16'h1800, 16'hffff, 1'b1);
      conv(16'h3000, 16'h0000, 1'b1);
      conv(16'h3000, 16'h0000, 1'b1);
      conv(16'h3000, 16'h0000, 1'b0);
      wr(8'hc0, 16'h0000, 0);
      wr(8'h86, 16'h0011, 1);
      conv(16'h1000, 16'h0000, 1'b1);
      conv(16'h2000, 16'h0000, 1'b1);
      conv(16'h0fff, 16'h0000, 1'b0);
      wr(8'hc0, 16'h0000, 0);
      check({15'h0, irq_n}, 16'h0001);
      // Test mode, then alert style; only the alert answer releases it
      wr(8'h86, 16'h0030, 1);
      check({15'h0, irq_n}, 16'h0000);
      host_u.alert_rd(b, a);
      // Answer carries the own address in bits 7:1, read flag set in bit 0
      check({7'h0, a, b}, {8'h0, `LSR_DEV_ADDR, 1'b1});
      repeat (4) @(posedge ref_clk);
      check({15'h0, irq_n}, 16'h0001);
      wr(8'h86, 16'h0020, 1);
      conv(16'h1800, 16'h0000, 1'b0);
      wr(8'hc0, 16'h0000, 0);
      check({15'h0, irq_n}, 16'h0000);
      host_u.alert_rd(b, a);
      repeat (4) @(posedge ref_clk);
      check({15'h0, irq_n}, 16'h0001);
      host_u.alert_rd(b, a);
      check({15'h0, a}, 16'h0001);
      final_report;
   end
endmodule
